// ### rtl/wdt_pkg.sv
// Purpose: Shared constants of the write-once watchdog timer
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: Offsets are byte indices on the register port
`default_nettype none

package wdt_pkg;
   // ==========================================
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_KEY = 8'h01;
   localparam logic [7:0] OFS_STATUS = 8'h02;
   localparam logic [7:0] OFS_MASK = 8'h03;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_STATE = 8'h05;

   // ==========================================
   // Mode register layout and values
   localparam int MODE_FIX_LSB = 5;
   localparam int MODE_STOP_BIT = 4;
   localparam int MODE_SEL_MSB = 2;
   localparam logic [2:0] MODE_FIXED = 3'h3;
   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [7:0] MODE_RD_MASK = 8'hf7;

   // ==========================================
   // Restart key register values
   localparam logic [7:0] KEY_RESTART = 8'hac;
   localparam logic [7:0] KEY_READBACK = 8'h9a;

   // ==========================================
   // Counter
   localparam int CNT_W = 18;
   localparam int OVF_BASE = 10;

   // ==========================================
   // Event and status bits
   localparam int NUM_EVT = 5;
   localparam int EVT_OVERFLOW = 0;
   localparam int EVT_BAD_KEY = 1;
   localparam int EVT_KEY_BITOP = 2;
   localparam int EVT_MODE_AGAIN = 3;
   localparam int EVT_SW_STOP = 4;
   localparam logic [4:0] MASK_RESET = 5'h00;

   // ==========================================
   // Configuration state
   typedef enum logic [2:0] {
      WDT_UNCONF = 3'h1,
      WDT_CONF = 3'h2,
      WDT_HALTED = 3'h4
   } wdt_cfg_t;
endpackage : wdt_pkg

`default_nettype wire

// ### rtl/wdt_sticky.sv
// Purpose: One sticky event flag, write-one-to-clear
// Assumes: Set and clear are single-cycle pulses
// Notes: A set in the clearing cycle wins
`default_nettype none

module wdt_sticky (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic set_in,
   input wire logic clear_in,
   output logic flag_out
);
   // ==========================================
   // Flag
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clear_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule : wdt_sticky

`default_nettype wire

// ### rtl/wdt_counter.sv
// Purpose: Watchdog up-counter with clear and count enable
// Assumes: Enable is one tick of the oscillator source
// Notes: Clear takes priority over counting
`default_nettype none

module wdt_counter #(
   parameter int WIDTH = 18
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clear_in,
   input wire logic count_in,
   output logic [WIDTH-1:0] value_out
);
   // ==========================================
   // Count
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         value_out <= '0;
      end else if (clear_in) begin
         value_out <= '0;
      end else if (count_in) begin
         value_out <= value_out + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule : wdt_counter

`default_nettype wire

// ### rtl/wdt_top.sv
// Purpose: Write-once watchdog timer with restart key
// Assumes: All inputs synchronous to clk_in
// Notes: Oscillator ticks arrive as one-cycle pulses
//        Internal reset is a one-cycle request; the system reset logic acts on it
//        The build option strap is read once after each reset release
//
// Function
// - A mode register write stalls the processor for one wait cycle.
// - Only the first byte write after reset configures the mode register.
// - A second mode register write raises the internal reset.
// - Reset causes while the source clock is stopped wait for it to resume.
// - Single-bit operations on the mode register do not configure it.
// - Software clock stop halts counting for good, without internal reset.
// - Writing anything but the restart key raises the internal reset.
// - A single-bit operation on the restart key register raises reset.
// - The restart key register reads a fixed value unlike the key.
// - Non-stoppable option counts always, also during STOP.
// - Counter overflow without restart raises the internal reset.
// - Stoppable option suspends counting during HALT and STOP.
// - After HALT or STOP the held count and clock selection resume.
`default_nettype none

module wdt_top (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [wdt_pkg::ADDR_W-1:0] addr_in,
   input wire logic [wdt_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic bit_op_in,
   output logic [wdt_pkg::DATA_W-1:0] rdata_out,
   input wire logic nonstop_option_in,
   input wire logic osc_tick_in,
   input wire logic halt_in,
   input wire logic stop_in,
   output logic cpu_wait_out,
   output logic internal_reset_out,
   output logic irq_out
);
   import wdt_pkg::*;

   // ==========================================
   // Declarations
   wdt_cfg_t cfg_state;
   wdt_cfg_t next_cfg_state;
   logic nonstop;
   logic strap_taken;
   logic [7:0] watchdog_mode;
   logic [NUM_EVT-1:0] irq_mask;
   logic [NUM_EVT-1:0] status;
   logic [NUM_EVT-1:0] events;
   logic [NUM_EVT-1:0] clear_bits;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;
   logic wr_mode;
   logic wr_key;
   logic mode_take;
   logic mode_fixed_ok;
   logic mode_again;
   logic key_good;
   logic key_bad;
   logic key_bitop;
   logic sw_stop;
   logic src_running;
   logic count_en;
   logic overflow;
   logic cause;
   logic pending;
   logic fire;
   logic cnt_clear;
   logic wr_status;
   logic wr_mask;
   logic cpu_asleep;
   logic [DATA_W-1:0] next_rdata;

   // ==========================================
   // Build option strap
   // Caught once after reset release, never under reset itself
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         strap_taken <= 1'b0;
         nonstop <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         nonstop <= nonstop_option_in;
      end
   end

   // ==========================================
   // Access decode
   assign wr_mode = wr_in && (addr_in == OFS_MODE);
   assign wr_key = wr_in && (addr_in == OFS_KEY);
   // Bit operations could clear flags they never meant to touch, so they are dropped
   assign wr_status = wr_in && !bit_op_in && (addr_in == OFS_STATUS);
   assign wr_mask = wr_in && (addr_in == OFS_MASK);

   // Upper bits must hold the fixed pattern when the oscillator cannot stop
   assign mode_fixed_ok = !nonstop ||
      (wdata_in[7:MODE_FIX_LSB] == MODE_FIXED);

   // Only a byte write in the unconfigured state configures
   assign mode_take = wr_mode && !bit_op_in &&
      (cfg_state == WDT_UNCONF);

   // Any write attempt after configuration is fatal
   assign mode_again = wr_mode && (cfg_state != WDT_UNCONF);

   // A bit operation on the key register is fatal whatever it writes
   always_comb begin
      key_good = 1'b0;
      key_bad = 1'b0;
      key_bitop = 1'b0;
      if (wr_key) begin
         if (bit_op_in) begin
            key_bitop = 1'b1;
         end else if (wdata_in == KEY_RESTART) begin
            key_good = 1'b1;
         end else begin
            key_bad = 1'b1;
         end
      end
   end

   // Software stop only exists with the stoppable option
   assign sw_stop = mode_take && mode_fixed_ok && !nonstop &&
      wdata_in[MODE_STOP_BIT];

   // ==========================================
   // Configuration state
   always_comb begin
      next_cfg_state = cfg_state;
      unique case (cfg_state)
         WDT_UNCONF: begin
            if (sw_stop) begin
               next_cfg_state = WDT_HALTED;
            end else if (mode_take) begin
               next_cfg_state = WDT_CONF;
            end
         end
         WDT_CONF: begin
            next_cfg_state = WDT_CONF;
         end
         WDT_HALTED: begin
            // Clearing the stop bit later cannot leave this state
            next_cfg_state = WDT_HALTED;
         end
         default: begin
            next_cfg_state = WDT_UNCONF;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cfg_state <= WDT_UNCONF;
      end else begin
         cfg_state <= next_cfg_state;
      end
   end

   // ==========================================
   // Mode register
   // A value with the wrong fixed bits is dropped, but the one write is used
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         watchdog_mode <= MODE_RESET;
      end else if (mode_take && mode_fixed_ok) begin
         watchdog_mode <= wdata_in;
      end
   end

   // Processor stall for the mode write
   // Bit operations stall too, since they are still mode writes
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cpu_wait_out <= 1'b0;
      end else begin
         cpu_wait_out <= wr_mode;
      end
   end

   // ==========================================
   // Source clock and counting
   // The clock selection lives in the mode register, so it survives HALT/STOP
   assign cpu_asleep = halt_in || stop_in;
   assign src_running = nonstop ||
      ((cfg_state != WDT_HALTED) && !cpu_asleep);

   assign count_en = osc_tick_in && src_running;

   // ==========================================
   // Period select
   // Overflow period doubles with each step of the selection field
   always_comb begin
      unique case (watchdog_mode[MODE_SEL_MSB:0])
         3'h0: begin
            limit = CNT_W'((1 << OVF_BASE) - 1);
         end
         3'h1: begin
            limit = CNT_W'((1 << (OVF_BASE + 1)) - 1);
         end
         3'h2: begin
            limit = CNT_W'((1 << (OVF_BASE + 2)) - 1);
         end
         3'h3: begin
            limit = CNT_W'((1 << (OVF_BASE + 3)) - 1);
         end
         3'h4: begin
            limit = CNT_W'((1 << (OVF_BASE + 4)) - 1);
         end
         3'h5: begin
            limit = CNT_W'((1 << (OVF_BASE + 5)) - 1);
         end
         3'h6: begin
            limit = CNT_W'((1 << (OVF_BASE + 6)) - 1);
         end
         3'h7: begin
            limit = CNT_W'((1 << (OVF_BASE + 7)) - 1);
         end
      endcase
   end

   // A late first write may pick a period shorter than the count so far
   assign overflow = count_en && (count >= limit);

   // Restart and an internal reset both start the count over
   assign cnt_clear = key_good || fire || overflow;

   wdt_counter #(
      .WIDTH(CNT_W)
   ) u_counter (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clear_in(cnt_clear),
      .count_in(count_en),
      .value_out(count)
   );

   // ==========================================
   // Internal reset request
   // Causes are held while the source clock is stopped
   assign cause = overflow || key_bad || key_bitop || mode_again;
   assign fire = pending && src_running;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pending <= 1'b0;
      end else if (cause) begin
         pending <= 1'b1;
      end else if (fire) begin
         pending <= 1'b0;
      end
   end

   // Registered so the request leaves as a clean one-cycle pulse
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         internal_reset_out <= 1'b0;
      end else begin
         internal_reset_out <= fire;
      end
   end

   // ==========================================
   // Event flags and interrupt
   assign events[EVT_OVERFLOW] = overflow;
   assign events[EVT_BAD_KEY] = key_bad;
   assign events[EVT_KEY_BITOP] = key_bitop;
   assign events[EVT_MODE_AGAIN] = mode_again;
   assign events[EVT_SW_STOP] = sw_stop;

   assign clear_bits = wr_status ? wdata_in[NUM_EVT-1:0] : '0;

   // Flags keep their event until software writes a one to them
   for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
      wdt_sticky u_flag (
         .clk_in(clk_in),
         .reset_n_in(reset_n_in),
         .set_in(events[i]),
         .clear_in(clear_bits[i]),
         .flag_out(status[i])
      );
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         irq_mask <= MASK_RESET;
      end else if (wr_mask) begin
         irq_mask <= wdata_in[NUM_EVT-1:0];
      end
   end

   // A set bit in the mask lets that event through
   assign irq_out = |(status & irq_mask);

   // ==========================================
   // Read port
   // Unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            OFS_MODE: begin
               next_rdata = watchdog_mode & MODE_RD_MASK;
            end
            OFS_KEY: begin
               next_rdata = KEY_READBACK;
            end
            OFS_STATUS: begin
               next_rdata = {{(8-NUM_EVT){1'b0}}, status};
            end
            OFS_MASK: begin
               next_rdata = {{(8-NUM_EVT){1'b0}}, irq_mask};
            end
            OFS_COUNT: begin
               next_rdata = count[CNT_W-1:CNT_W-8];
            end
            OFS_STATE: begin
               next_rdata = {2'h0, nonstop, src_running, pending, cfg_state};
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // Data stands one cycle only, so a stale value never looks like a fresh read
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= next_rdata;
      end
   end
endmodule : wdt_top

`default_nettype wire

// ### sim/wdt_checker.sv
// Purpose: Port assertions for the write-once watchdog
// Assumes: Strap steady per reset; reset held 3 cycles or more
// Notes: Internal reset latency allowed as 1 to 3 cycles
`default_nettype none

module wdt_checker (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [wdt_pkg::ADDR_W-1:0] addr_in,
   input wire logic [wdt_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic bit_op_in,
   input wire logic [wdt_pkg::DATA_W-1:0] rdata_out,
   input wire logic nonstop_option_in,
   input wire logic halt_in,
   input wire logic stop_in,
   input wire logic cpu_wait_out,
   input wire logic internal_reset_out
);
   import wdt_pkg::*;
   logic cfg_done;
   logic sw_off;
   wire logic mode_wr = wr_in && addr_in == OFS_MODE;
   wire logic key_wr = wr_in && addr_in == OFS_KEY;
   // ==========================================
   // First mode write; bit ops do not use it up
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cfg_done <= 1'h0;
         sw_off <= 1'h0;
      end else if (mode_wr && !bit_op_in && !cfg_done) begin
         cfg_done <= 1'h1;
         sw_off <= !nonstop_option_in && wdata_in[MODE_STOP_BIT];
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_rst_soon;
      ##[1:3] internal_reset_out;
   endsequence
   AST_WAIT: assert property (mode_wr |=> cpu_wait_out)
      else $error("no wait after mode write");
   AST_WAIT_CAUSE: assert property (cpu_wait_out |-> $past(mode_wr))
      else $error("wait without mode write");
   AST_AGAIN: assert property (nonstop_option_in && mode_wr && !bit_op_in && cfg_done |-> s_rst_soon)
      else $error("second mode write did not reset");
   AST_BAD_KEY: assert property (nonstop_option_in && key_wr && wdata_in != KEY_RESTART |-> s_rst_soon)
      else $error("bad key did not reset");
   AST_KEY_BITOP: assert property (nonstop_option_in && key_wr && bit_op_in |-> s_rst_soon)
      else $error("bit op on key did not reset");
   AST_READBACK: assert property (rd_in && addr_in == OFS_KEY |=> rdata_out == KEY_READBACK)
      else $error("key readback wrong");
   AST_DEFER: assert property (!nonstop_option_in && (halt_in || stop_in) [*4] |-> !internal_reset_out)
      else $error("reset while source stopped");
   AST_SW_STOP: assert property ($past(sw_off, 3) |-> !internal_reset_out)
      else $error("reset after software stop");
endmodule : wdt_checker

bind wdt_top wdt_checker u_wdt_checker (.*);

`default_nettype wire

// ### sim/wdt_top_tb.sv
// Purpose: Self-checking bench for wdt_top
// Assumes: Internal reset is a request only; registers survive it
// Notes: Strap changes only under reset
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end

module wdt_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import wdt_pkg::*;
   logic clk_in = 1'h0, reset_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0, bit_op_in = 1'h0;
   logic nonstop_option_in = 1'h1, osc_tick_in = 1'h0, halt_in = 1'h0, stop_in = 1'h0;
   logic cpu_wait_out, internal_reset_out, irq_out;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, d;
   int miscompares = 0, n_compared = 0, k;
   always #5 clk_in = ~clk_in;
   wdt_top u_wdt_top (.*);
   // ==========================================
   // Bus and wait helpers
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic b);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      bit_op_in <= b;
      wr_in <= 1'h1;
      @(posedge clk_in);
      wr_in <= 1'h0;
      bit_op_in <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'h1;
      @(posedge clk_in);
      rd_in <= 1'h0;
      #1 d = rdata_out;
   endtask : rd
   // Leaves k at n when no pulse came
   task automatic pulse(input int n);
      for (k = 0; k < n; k++) begin
         @(posedge clk_in);
         #1;
         if (internal_reset_out === 1'h1) break;
      end
   endtask : pulse
   task automatic rst(input logic ns);
      @(posedge clk_in);
      reset_n_in <= 1'h0;
      nonstop_option_in <= ns;
      osc_tick_in <= 1'h0;
      halt_in <= 1'h0;
      stop_in <= 1'h0;
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      osc_tick_in <= 1'h1;
   endtask : rst
   // ==========================================
   // Scenarios
   task automatic t_once;
      rd(OFS_KEY);
      `CHK("key read", KEY_READBACK, d)
      rd(8'h7f);
      `CHK("unmapped", 8'h00, d)
      wr(OFS_MODE, 8'h70, 1'h1);
      rd(OFS_MODE);
      `CHK("bitop mode", MODE_RESET & MODE_RD_MASK, d)
      wr(OFS_MODE, 8'h63, 1'h0);
      #1;
      `CHK("wait", 1'h1, cpu_wait_out)
      wr(OFS_MODE, 8'h60, 1'h0);
      pulse(4);
      `CHK("again rst", 1'h1, k < 4)
      rd(OFS_MODE);
      `CHK("mode kept", 8'h63, d)
   endtask : t_once
   task automatic t_keys;
      logic [7:0] bad [4] = '{8'h00, 8'hab, 8'h9a, 8'hff};
      wr(OFS_MASK, 8'h06, 1'h0);
      foreach (bad[i]) begin
         wr(OFS_KEY, bad[i], 1'h0);
         pulse(4);
         `CHK("bad key rst", 1'h1, k < 4)
      end
      `CHK("irq set", 1'h1, irq_out)
      wr(OFS_STATUS, 8'h02, 1'h0);
      #1;
      `CHK("irq clr", 1'h0, irq_out)
      wr(OFS_KEY, KEY_RESTART, 1'h1);
      pulse(4);
      `CHK("bitop key rst", 1'h1, k < 4)
      `CHK("irq bitop", 1'h1, irq_out)
   endtask : t_keys
   task automatic t_nonstop;
      rst(1'h1);
      wr(OFS_MODE, 8'h61, 1'h0);
      stop_in <= 1'h1;
      pulse(1500);
      `CHK("no early rst", 1500, k)
      rd(OFS_COUNT);
      `CHK("count in stop", 8'h01, d)
      wr(OFS_KEY, KEY_RESTART, 1'h0);
      rd(OFS_COUNT);
      `CHK("count cleared", 8'h00, d)
      pulse(2100);
      `CHK("ovf time", 1'h1, k > (1 << (OVF_BASE + 1)) - 60 && k < 2100)
   endtask : t_nonstop
   task automatic t_hold;
      rst(1'h0);
      wr(OFS_MODE, 8'h62, 1'h0);
      pulse(2500);
      halt_in <= 1'h1;
      pulse(3000);
      `CHK("halt no rst", 3000, k)
      rd(OFS_COUNT);
      `CHK("count held", 8'h02, d)
      halt_in <= 1'h0;
      rd(OFS_COUNT);
      `CHK("count kept", 8'h02, d)
      halt_in <= 1'h1;
      wr(OFS_KEY, 8'h00, 1'h0);
      pulse(20);
      `CHK("deferred", 20, k)
      halt_in <= 1'h0;
      pulse(4);
      `CHK("resume rst", 1'h1, k < 4)
   endtask : t_hold
   task automatic t_swstop;
      rst(1'h0);
      wr(OFS_MODE, 8'h70, 1'h0);
      wr(OFS_KEY, 8'h00, 1'h0);
      pulse(1200);
      `CHK("stopped", 1200, k)
      rd(OFS_STATE);
      `CHK("halted", WDT_HALTED, d[2:0])
   endtask : t_swstop
   // ==========================================
   // Verdict and run control
   task automatic wrap_up;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #300000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk_in);
      reset_n_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      t_once();
      t_keys();
      t_nonstop();
      t_hold();
      t_swstop();
      wrap_up();
   end
endmodule : wdt_top_tb

`default_nettype wire
